// >>> hdl/acs_pkg.sv
/*
 * Shared constants and types of the converter serial port pair.
 * Assumes a 125 MHz pclk on both ends; times are converted to cycles here.
 */
package acs_pkg;
  // ****************************************
  // Configuration word layout
  // ****************************************
  localparam int CFG_W = 14;
  localparam int RES_W = 16;
  localparam int OUT_W = RES_W + CFG_W + 1;
  localparam int UPD_BIT = 13;
  localparam int INPUT_CONFIG_FIELD_MSB = 12;
  localparam int INPUT_CONFIG_FIELD_LSB = 10;
  localparam int CHAN_MSB = 9;
  localparam int CHAN_LSB = 7;
  localparam int BW_BIT = 6;
  localparam int REF_MSB = 5;
  localparam int REF_LSB = 3;
  localparam int SEQ_MSB = 2;
  localparam int SEQ_LSB = 1;
  localparam int RBD_BIT = 0;
  localparam logic [CFG_W-1:0] CFG_RESET = 14'h0000;
  localparam logic [CFG_W-1:0] CFG_DEFAULT = 14'h3fff;
  // ****************************************
  // Timing
  // ****************************************
  localparam int PCLK_NS = 8;
  localparam int CONV_TIME_NS = 4000;
  localparam int CONV_CYC = CONV_TIME_NS / PCLK_NS;
  localparam int CNV_HIGH_NS = 40;
  localparam int CNV_HIGH_CYC = (CNV_HIGH_NS + PCLK_NS - 1) / PCLK_NS;
  localparam int SCK_PERIOD_NS = 160;
  localparam int SCK_HALF_CYC = (SCK_PERIOD_NS / 2 + PCLK_NS - 1) / PCLK_NS;
  localparam int WAIT_MARGIN_CYC = 8;
  localparam int BURST1_BITS = 16;
  // ****************************************
  // Host registers on APB
  // ****************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_TXCFG = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_RESULT = 8'h0c;
  localparam logic [7:0] REG_RBCFG = 8'h10;
  localparam int CTRL_START = 0;
  localparam int CTRL_PRELOAD = 1;
  localparam int CTRL_RB = 2;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_VALID = 2;
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    IM_BIPOLAR_PAIRS = 3'h0,
    IM_PSEUDO_BIPOLAR = 3'h1,
    IM_TEMP_SENSOR = 3'h2,
    IM_UNIPOLAR_PAIRS = 3'h3,
    IM_PSEUDO_DIFF = 3'h4,
    IM_SINGLE_ENDED = 3'h5
  } acs_input_mode_type;
  typedef enum logic [2:0] {
    HS_IDLE = 3'h0,
    HS_BURST1 = 3'h1,
    HS_CNV_HIGH = 3'h2,
    HS_BURST2 = 3'h3,
    HS_WAIT = 3'h4
  } acs_host_state_type;
  // Maps the input configuration field to a mode
  function automatic acs_input_mode_type acs_decode_input(input logic [2:0] f);
    acs_input_mode_type m;
    m = IM_SINGLE_ENDED;
    if (f[2:1] == 2'h0) m = IM_BIPOLAR_PAIRS;
    else if (f == 3'h2) m = IM_PSEUDO_BIPOLAR;
    else if (f == 3'h3) m = IM_TEMP_SENSOR;
    else if (f[2:1] == 2'h2) m = IM_UNIPOLAR_PAIRS;
    else if (f == 3'h6) m = IM_PSEUDO_DIFF;
    return m;
  endfunction
endpackage

// >>> hdl/acs_link_if.sv
/*
 * Four-wire link between the converter end and the host end.
 * Assumes the bench joins both modports; all wires are one-way.
 */
`timescale 1ns/1ps
interface acs_link_if;
  logic convert_strobe;
  logic sclk;
  logic sdi;
  logic sdo;
  modport dev(input convert_strobe, input sclk, input sdi, output sdo);
  modport host(output convert_strobe, output sclk, output sdi, input sdo);
endinterface

// >>> hdl/acs_adc_dev.sv
/*
 * Converter end: serial configuration capture, result shift-out and
 * conversion timing of the documented converter, modelled in logic.
 * Assumes link pins are asynchronous to pclk and are synchronised here.
 */
`timescale 1ns/1ps
module acs_adc_dev
  import acs_pkg::*;
#(
  parameter int CONV_CYC_P = CONV_CYC
) (
  input logic pclk, // System clock
  input logic presetn, // Async reset
  acs_link_if.dev link, // Serial link
  input logic [RES_W-1:0] sample_in, // Value to convert
  input logic busy_mode, // Leading busy bit on
  output logic [CFG_W-1:0] cfg_q, // Active configuration
  output acs_input_mode_type mode_q, // Decoded input mode
  output logic converting_q, // Conversion running
  output logic conv_done_q, // Conversion end pulse
  output logic cfg_valid_q // Two conversions seen
);
  localparam int CW = $clog2(CONV_CYC_P + 1);

  // ****************************************
  // Parameter check
  // ****************************************
  if (CONV_CYC_P < 8) begin : g_chk
    $error("CONV_CYC_P too small for synchroniser delay");
  end

  // ****************************************
  // Pin synchronisers and edge detect
  // ****************************************
  logic [2:0] meta_q;
  logic [2:0] sync_q;
  logic sck_last_q;
  logic cnv_last_q;
  wire cnv_s = sync_q[0];
  wire sck_s = sync_q[1];
  wire din_s = sync_q[2];

  // Two flops per pin, then one history flop on the strobe and the clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 3'h0;
      sync_q <= 3'h0;
      sck_last_q <= 1'b0;
      cnv_last_q <= 1'b0;
    end else begin
      meta_q <= {link.sdi, link.sclk, link.convert_strobe};
      sync_q <= meta_q;
      sck_last_q <= sck_s;
      cnv_last_q <= cnv_s;
    end
  end

  // Edges; clock edges while the strobe is high do nothing
  wire cnv_rise = cnv_s & ~cnv_last_q;
  wire sck_rise = sck_s & ~sck_last_q & ~cnv_s;
  wire sck_fall = ~sck_s & sck_last_q & ~cnv_s;

  // ****************************************
  // Conversion timing
  // ****************************************
  logic [CW-1:0] cnt_q;
  logic [RES_W-1:0] hold_q;
  logic [CFG_W-1:0] cfg_used_q;
  logic [RES_W-1:0] result_q;
  logic [CFG_W-1:0] rb_cfg_q;
  wire conv_start = cnv_rise & ~converting_q;
  wire conv_end = converting_q && (cnt_q == CW'(CONV_CYC_P - 1));

  // Conversion counter; a strobe rise while busy is ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      converting_q <= 1'b0;
      cnt_q <= '0;
      conv_done_q <= 1'b0;
    end else begin
      conv_done_q <= conv_end;
      if (conv_start) begin
        converting_q <= 1'b1;
        cnt_q <= '0;
      end else if (conv_end) begin
        converting_q <= 1'b0;
      end else if (converting_q) begin
        cnt_q <= cnt_q + CW'(1);
      end
    end
  end

  // Sample and the configuration in force are held at start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_q <= '0;
      cfg_used_q <= CFG_RESET;
      result_q <= '0;
      rb_cfg_q <= CFG_RESET;
    end else begin
      if (conv_start) begin
        hold_q <= sample_in;
        cfg_used_q <= cfg_q;
      end
      if (conv_end) begin
        result_q <= hold_q;
        rb_cfg_q <= cfg_used_q;
      end
    end
  end

  // ****************************************
  // Configuration shift-in
  // ****************************************
  logic [CFG_W-1:0] shift_in_q;
  logic [3:0] bits_q;
  logic [CFG_W-1:0] pend_q;
  logic pend_vld_q;
  wire bits_full = (bits_q == 4'(CFG_W));
  wire word_done = sck_rise && (bits_q == 4'(CFG_W - 1));
  wire [CFG_W-1:0] shift_in_d = {shift_in_q[CFG_W-2:0], din_s};

  // Bits taken on rising edges in any phase; the count restarts
  // at each conversion end, so a partial word is dropped there
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_in_q <= '0;
      bits_q <= 4'h0;
    end else if (conv_end) begin
      bits_q <= 4'h0;
    end else if (sck_rise && !bits_full) begin
      shift_in_q <= shift_in_d;
      bits_q <= bits_q + 4'h1;
    end
  end

  // Complete word waits for the conversion end; set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q <= '0;
      pend_vld_q <= 1'b0;
    end else if (word_done) begin
      pend_q <= shift_in_d;
      pend_vld_q <= 1'b1;
    end else if (conv_end) begin
      pend_vld_q <= 1'b0;
    end
  end

  // ****************************************
  // Configuration apply
  // ****************************************
  wire take_new = pend_vld_q & pend_q[UPD_BIT];
  wire [CFG_W-1:0] cfg_d = take_new ? pend_q : cfg_q;
  wire [2:0] input_config_field_d = cfg_d[INPUT_CONFIG_FIELD_MSB:INPUT_CONFIG_FIELD_LSB];
  logic [1:0] dummy_q;

  // Word becomes active only at a conversion end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= CFG_RESET;
      mode_q <= IM_BIPOLAR_PAIRS;
    end else if (conv_end) begin
      cfg_q <= cfg_d;
      mode_q <= acs_decode_input(input_config_field_d);
    end
  end

  // Configuration counts as known after two conversion ends
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dummy_q <= 2'h0;
      cfg_valid_q <= 1'b0;
    end else if (conv_end && dummy_q != 2'h2) begin
      dummy_q <= dummy_q + 2'h1;
      cfg_valid_q <= (dummy_q == 2'h1);
    end
  end

  // ****************************************
  // Result shift-out
  // ****************************************
  logic [OUT_W-1:0] out_q;
  logic sdo_q;
  logic loaded_q;
  // Readback word is blanked when readback is disabled
  wire [CFG_W-1:0] rb_word = rb_cfg_q[RBD_BIT] ? '0 : rb_cfg_q;
  // Optional busy bit precedes the result; the 0x3fff
  // default disables readback and sets every field high
  wire [OUT_W-1:0] frame_busy = {1'b0, result_q, rb_word};
  wire [OUT_W-1:0] frame_plain = {result_q, rb_word, 1'b0};
  wire [OUT_W-1:0] frame = busy_mode ? frame_busy : frame_plain;

  // Frame loaded after each conversion end, so an access in
  // acquisition n and conversion n sees result n-1
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loaded_q <= 1'b0;
    end else begin
      loaded_q <= conv_end;
    end
  end

  // Each falling edge moves the next bit up; zeros follow
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_q <= '0;
    end else if (loaded_q) begin
      out_q <= frame;
    end else if (sck_fall) begin
      out_q <= {out_q[OUT_W-2:0], 1'b0};
    end
  end

  // Data out pin driven from its own flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sdo_q <= 1'b0;
    end else begin
      sdo_q <= out_q[OUT_W-1];
    end
  end

  assign link.sdo = sdo_q;

  // The all-ones word decodes to single-ended inputs
  // with filter, buffer and sequencer bits set high
  // (decode in acs_decode_input, field layout in acs_pkg)
endmodule

// >>> hdl/acs_host.sv
/*
 * Host end: APB slave registers and a sequencer that runs one spanning
 * access per start: burst, strobe pulse, second burst if bits remain, wait for conversion end.
 * Assumes APB on pclk and the converter on the other side of the link.
 */
`timescale 1ns/1ps
module acs_host
  import acs_pkg::*;
#(
  parameter int HALF_P = SCK_HALF_CYC,
  parameter int B1_P = BURST1_BITS,
  parameter int WAIT_P = CONV_CYC + WAIT_MARGIN_CYC
) (
  input logic pclk, // System clock
  input logic presetn, // Async reset
  acs_link_if.host link, // Serial link
  input logic psel, // APB select
  input logic penable, // APB enable
  input logic pwrite, // APB write
  input logic [7:0] paddr, // APB address
  input logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata_q, // APB read data
  output logic pready_q, // APB ready
  output logic pslverr_q // APB error
);
  // ****************************************
  // Parameter check
  // ****************************************
  if (HALF_P < 7 || B1_P < 1 || B1_P > 30 || WAIT_P > 4095) begin : g_chk
    $error("acs_host parameter out of range");
  end

  // ****************************************
  // APB slave
  // ****************************************
  acs_host_state_type st_q;
  logic preload_q, rb_q, done_q;
  logic [1:0] nconv_q;
  logic [CFG_W-1:0] txcfg_q, rbcfg_q;
  logic [RES_W-1:0] result_q;
  wire busy = (st_q != HS_IDLE);
  wire acc = psel & penable;
  wire wr_now = acc & pready_q & pwrite;
  wire hit_ctrl = (paddr == REG_CTRL);
  wire hit_tx = (paddr == REG_TXCFG);
  wire hit_st = (paddr == REG_STATUS);
  wire hit_res = (paddr == REG_RESULT);
  wire hit_rb = (paddr == REG_RBCFG);
  wire mapped = hit_ctrl | hit_tx | hit_st | hit_res | hit_rb;
  wire [31:0] status_w = {29'h0, nconv_q == 2'h2, done_q, busy};
  wire [31:0] ctrl_w = {29'h0, rb_q, preload_q, 1'b0};
  wire [31:0] rd_mux = hit_ctrl ? ctrl_w
                     : hit_tx ? {18'h0, txcfg_q}
                     : hit_st ? status_w
                     : hit_res ? {16'h0, result_q}
                     : hit_rb ? {18'h0, rbcfg_q} : 32'h0;
  wire start = wr_now & hit_ctrl & pwdata[CTRL_START] & ~busy;

  // One wait state, then ready with data or error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= acc & ~pready_q;
      prdata_q <= (acc & ~pready_q & ~pwrite) ? rd_mux : 32'h0;
      pslverr_q <= acc & ~pready_q & ~mapped;
    end
  end

  // Register writes take effect at the ready edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txcfg_q <= CFG_DEFAULT;
      preload_q <= 1'b0;
      rb_q <= 1'b0;
    end else if (wr_now && hit_tx) begin
      txcfg_q <= pwdata[CFG_W-1:0];
    end else if (wr_now && hit_ctrl && !busy) begin
      preload_q <= pwdata[CTRL_PRELOAD];
      rb_q <= pwdata[CTRL_RB];
    end
  end

  // ****************************************
  // Link sequencer
  // ****************************************
  logic sdo_meta_q, sdo_s_q;
  logic cnv_q, sck_q, sdi_q;
  logic [7:0] ph_q;
  logic [4:0] bit_q;
  logic [11:0] cnt_q;
  logic [CFG_W-1:0] tx_q;
  logic [OUT_W-2:0] rx_q;
  wire [4:0] total = rb_q ? 5'(RES_W + CFG_W) : 5'(RES_W);
  wire [4:0] b1_end = (5'(B1_P) < total) ? 5'(B1_P) : total;
  wire in_burst = (st_q == HS_BURST1) | (st_q == HS_BURST2);
  wire half_done = (ph_q == 8'(HALF_P - 1));
  wire bit_end = in_burst & half_done & sck_q;
  wire [4:0] bit_nx = bit_q + 5'h1;
  // Strobe rises only after a half period of quiet sclk
  wire cnv_on = (st_q == HS_CNV_HIGH) & ~cnv_q & (cnt_q == 12'(HALF_P - 1));
  wire cnv_end = cnv_q & (cnt_q == 12'(CNV_HIGH_CYC - 1));
  wire wait_end = (cnt_q == 12'(WAIT_P - 1));

  // Data out pin passes two flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sdo_meta_q <= 1'b0;
      sdo_s_q <= 1'b0;
    end else begin
      sdo_meta_q <= link.sdo;
      sdo_s_q <= sdo_meta_q;
    end
  end

  // State flow: bursts only while the strobe is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= HS_IDLE;
      cnv_q <= 1'b0;
    end else begin
      case (st_q)
        HS_IDLE: begin
          if (start) st_q <= HS_BURST1;
        end
        HS_BURST1: begin
          if (bit_end && bit_nx == b1_end) begin
            st_q <= HS_CNV_HIGH;
          end
        end
        HS_CNV_HIGH: begin
          if (cnv_on) cnv_q <= 1'b1;
          if (cnv_end) begin
            cnv_q <= 1'b0;
            st_q <= (bit_q == total) ? HS_WAIT : HS_BURST2;
          end
        end
        HS_BURST2: begin
          if (bit_end && bit_nx == total) st_q <= HS_WAIT;
        end
        HS_WAIT: begin
          if (wait_end) st_q <= HS_IDLE;
        end
        default: st_q <= HS_IDLE;
      endcase
    end
  end

  // Cycle count from the strobe rise to the conversion end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 12'h0;
    end else if (st_q == HS_IDLE || st_q == HS_BURST1 || cnv_on) begin
      cnt_q <= 12'h0;
    end else begin
      cnt_q <= cnt_q + 12'h1;
    end
  end

  // Serial clock divider; data out sampled on rising edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_q <= 8'h0;
      sck_q <= 1'b0;
      bit_q <= 5'h0;
      rx_q <= '0;
    end else if (start) begin
      ph_q <= 8'h0;
      bit_q <= 5'h0;
    end else if (in_burst) begin
      ph_q <= half_done ? 8'h0 : ph_q + 8'h1;
      if (half_done) sck_q <= ~sck_q;
      if (half_done && !sck_q) rx_q <= {rx_q[OUT_W-3:0], sdo_s_q};
      if (bit_end) bit_q <= bit_nx;
    end else begin
      ph_q <= 8'h0;
    end
  end

  // Word out MSB first, changed while the clock is low;
  // preload holds data high for the whole access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_q <= '0;
      sdi_q <= 1'b0;
    end else begin
      if (start) tx_q <= txcfg_q;
      else if (bit_end) tx_q <= {tx_q[CFG_W-2:0], 1'b0};
      sdi_q <= preload_q | tx_q[CFG_W-1];
    end
  end

  // Results and flags at the end of each access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_q <= 1'b0;
      nconv_q <= 2'h0;
      result_q <= '0;
      rbcfg_q <= '0;
    end else if (st_q == HS_WAIT && wait_end) begin
      done_q <= 1'b1;
      if (nconv_q != 2'h2) nconv_q <= nconv_q + 2'h1;
      result_q <= rb_q ? rx_q[OUT_W-2:CFG_W] : rx_q[RES_W-1:0];
      rbcfg_q <= rb_q ? rx_q[CFG_W-1:0] : '0;
    end else if (start) begin
      done_q <= 1'b0;
    end
  end

  assign link.convert_strobe = cnv_q;
  assign link.sclk = sck_q;
  assign link.sdi = sdi_q;
endmodule

// >>> tb/acs_link_monitor.sv
/*
 * Checker for the four link wires between the host end and the converter end.
 * Assumes the host end runs with a sclk half period of HALF_P pclk cycles.
 */
`timescale 1ns/1ps
module acs_link_monitor #(
  parameter int HALF_P = 6
) (
  input logic pclk, // System clock
  input logic presetn, // Async reset
  input logic convert_strobe, // Conversion strobe
  input logic sclk, // Serial clock
  input logic sdi, // Data to converter
  input logic sdo // Data from converter
);
  // ****************
  // Helper logic
  // ****************
  logic [7:0] hi_cnt_q;
  // Counts cycles with sclk high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) hi_cnt_q <= 8'h00;
    else if (sclk) hi_cnt_q <= hi_cnt_q + 8'h01;
    else hi_cnt_q <= 8'h00;
  end
  // ****************
  // Assertions
  // ****************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_pulse;
    convert_strobe [*5] ##1 !convert_strobe;
  endsequence
  sequence s_quiet;
    !sclk [*2];
  endsequence
  a_strobe_no_sclk: assert property (convert_strobe |-> !sclk)
    else $error("sclk high while strobe high");
  a_strobe_width: assert property ($rose(convert_strobe) |-> s_pulse)
    else $error("strobe pulse width wrong");
  a_quiet_before: assert property ($rose(convert_strobe) |->
    !$past(sclk) && !$past(sclk, 2) && !$past(sclk, 3))
    else $error("sclk active just before strobe");
  a_quiet_after: assert property ($fell(convert_strobe) |-> s_quiet)
    else $error("sclk active just after strobe");
  a_sclk_high_time: assert property ($fell(sclk) |-> hi_cnt_q == 8'(HALF_P))
    else $error("sclk high time wrong");
  a_sdi_hold: assert property (sclk && $past(sclk) |-> $stable(sdi))
    else $error("sdi moved while sclk high");
  a_sdo_hold: assert property (sclk && $past(sclk) |-> $stable(sdo))
    else $error("sdo moved while sclk high");
  a_strobe_gap: assert property ($fell(convert_strobe) |-> !convert_strobe [*8])
    else $error("strobe rose again too soon");
endmodule

// >>> tb/tb_top.sv
/*
 * Testbench: host end and converter end joined on one link, plus a second
 * converter end worked bit by bit from the bench.
 * Assumes shortened conversion and sclk counts set at the instances.
 */
`timescale 1ns/1ps
module tb_top;
  import acs_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready_q, pslverr_q, conv_done_b, valid_a;
  logic busy_b, conv_b;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata_q;
  logic [15:0] sample_a, sample_b;
  logic [CFG_W-1:0] cfg_a, cfg_b;
  acs_input_mode_type mode_a;
  int fail_count, tests_run;
  acs_link_if link_a();
  acs_link_if link_b();
  // ****************
  // Instances
  // ****************
  acs_host #(.HALF_P(8), .WAIT_P(328)) acs_host_inst (.pclk(pclk), .presetn(presetn),
    .link(link_a.host), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q));
  acs_adc_dev #(.CONV_CYC_P(320)) acs_adc_dev_inst (.pclk(pclk), .presetn(presetn),
    .link(link_a.dev), .sample_in(sample_a), .busy_mode(1'b0), .cfg_q(cfg_a),
    .mode_q(mode_a), .converting_q(), .conv_done_q(), .cfg_valid_q(valid_a));
  acs_adc_dev #(.CONV_CYC_P(320)) acs_adc_dev_inst_b (.pclk(pclk), .presetn(presetn),
    .link(link_b.dev), .sample_in(sample_b), .busy_mode(busy_b), .cfg_q(cfg_b),
    .mode_q(), .converting_q(conv_b), .conv_done_q(conv_done_b), .cfg_valid_q());
  acs_link_monitor #(.HALF_P(8)) acs_link_monitor_inst (.pclk(pclk), .presetn(presetn),
    .convert_strobe(link_a.convert_strobe), .sclk(link_a.sclk), .sdi(link_a.sdi),
    .sdo(link_a.sdo));
  // Free-running 125 MHz clock
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // ****************
  // Shared tasks
  // ****************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic hang();
    chk("wait", 32'h1, 32'h0);
    complete_run();
  endtask
  // One APB transfer; holds the request until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready_q !== 1'b1 && n < 20);
    if (n >= 20) hang();
    r = prdata_q;
    err = pslverr_q;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Starts one host access and polls until it is over
  task automatic access(input logic [31:0] ctrl, input logic [31:0] txcfg, output logic [31:0] r);
    logic e;
    int n;
    apb(1'b1, REG_TXCFG, txcfg, r, e);
    apb(1'b1, REG_CTRL, ctrl, r, e);
    n = 0;
    do begin
      apb(1'b0, REG_STATUS, 32'h0, r, e);
      n++;
    end while (r[STAT_BUSY] !== 1'b0 && n < 400);
    if (n >= 400) hang();
    apb(1'b0, REG_RESULT, 32'h0, r, e);
  endtask
  // Bit-bangs n bits on link_b, MSB first, gathering sdo before each fall
  task automatic bang(input logic [29:0] w, input int n, output logic [29:0] got);
    got = 30'h0;
    for (int i = 0; i < n; i++) begin
      link_b.sdi <= w[n-1-i];
      repeat (10) @(posedge pclk);
      link_b.sclk <= 1'b1;
      repeat (10) @(posedge pclk);
      got = {got[28:0], link_b.sdo};
      link_b.sclk <= 1'b0;
    end
    repeat (10) @(posedge pclk);
  endtask
  task automatic wait_b();
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (conv_done_b !== 1'b1 && n < 400);
    if (n >= 400) hang();
    repeat (6) @(posedge pclk);
  endtask
  task automatic pulse_b();
    link_b.convert_strobe <= 1'b1;
    repeat (5) @(posedge pclk);
    link_b.convert_strobe <= 1'b0;
    wait_b();
  endtask
  function automatic logic [2:0] exp_mode(input logic [2:0] f);
    case (f)
      3'h0, 3'h1: return IM_BIPOLAR_PAIRS;
      3'h2: return IM_PSEUDO_BIPOLAR;
      3'h3: return IM_TEMP_SENSOR;
      3'h4, 3'h5: return IM_UNIPOLAR_PAIRS;
      3'h6: return IM_PSEUDO_DIFF;
      default: return IM_SINGLE_ENDED;
    endcase
  endfunction
  // ****************
  // Scenarios
  // ****************
  task automatic t_host();
    logic [31:0] r;
    logic e;
    sample_a <= 16'ha5c3;
    access(32'h3, 32'h0, r);
    chk("cfg_valid", 32'h0, valid_a);
    access(32'h3, 32'h0, r);
    chk("cfg", CFG_DEFAULT, cfg_a);
    chk("cfg_valid", 32'h1, valid_a);
    chk("mode", IM_SINGLE_ENDED, mode_a);
    sample_a <= 16'h1234;
    access(32'h1, 32'h2c92, r);
    chk("result", 32'ha5c3, r);
    chk("cfg", 32'h2c92, cfg_a);
    sample_a <= 16'h0bee;
    access(32'h1, 32'h0155, r);
    chk("result", 32'h1234, r);
    chk("cfg", 32'h2c92, cfg_a);
    access(32'h5, 32'h0155, r);
    chk("result", 32'h0bee, r);
    apb(1'b0, REG_RBCFG, 32'h0, r, e);
    chk("readback", 32'h2c92, r);
    for (int f = 0; f < 8; f++) begin
      access(32'h1, {18'h0, 1'b1, f[2:0], 10'h3ff}, r);
      chk("mode", exp_mode(f[2:0]), mode_a);
    end
    apb(1'b0, 8'h20, 32'h0, r, e);
    chk("unmapped err", 32'h1, e);
    chk("unmapped data", 32'h0, r);
    $display("test host end done");
  endtask
  task automatic t_direct();
    logic [29:0] got;
    sample_b <= 16'hc35a;
    bang(30'h3a5c, 14, got);
    pulse_b();
    chk("cfg_b", 32'h3a5c, cfg_b);
    bang(30'h0, 16, got);
    chk("sdo result", 32'hc35a, got[15:0]);
    pulse_b();
    chk("cfg_b", 32'h3a5c, cfg_b);
    bang(30'h3ff, 10, got);
    pulse_b();
    chk("cfg_b", 32'h3a5c, cfg_b);
    sample_b <= 16'h9b3d;
    busy_b <= 1'b1;
    link_b.convert_strobe <= 1'b1;
    bang(30'h3fff, 14, got);
    chk("converting", 32'h1, conv_b);
    wait_b();
    link_b.convert_strobe <= 1'b0;
    repeat (6) @(posedge pclk);
    chk("cfg_b", 32'h3a5c, cfg_b);
    bang(30'h0, 17, got);
    chk("sdo busy", 32'h00009b3d, got[16:0]);
    $display("test direct end done");
  endtask
  // Main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    sample_a = 16'h0;
    sample_b = 16'h0;
    busy_b = 1'b0;
    link_b.convert_strobe = 1'b0;
    link_b.sclk = 1'b0;
    link_b.sdi = 1'b0;
    fail_count = 0;
    tests_run = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_host();
    t_direct();
    complete_run();
  end
endmodule
